/* File: rtl/apf_pkg.sv */
package apf_pkg;
    localparam int unsigned DATA_W = 9;
    localparam int unsigned DEPTH = 8192;
    localparam int unsigned HALF_DEPTH = DEPTH / 2;
    localparam int unsigned CNT_W = 14;

    // register byte offsets on the AHB-Lite side
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0c;
    localparam logic [7:0] OFF_COUNT = 8'h10;

    // control field positions
    localparam int unsigned CTRL_RESET_BIT = 0;
    localparam int unsigned CTRL_REWIND_BIT = 1;
    localparam int unsigned CTRL_CHAIN_BIT = 2;
    localparam int unsigned CTRL_FIRST_BIT = 3;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

    // status field positions
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_EMPTY_BIT = 1;
    localparam int unsigned ST_FULL_BIT = 2;
    localparam int unsigned ST_HALF_BIT = 3;
    localparam int unsigned ST_RVALID_BIT = 4;
    localparam int unsigned ST_INIT_BIT = 5;

    // timing, in ns, and derived cycle counts at 4 ns
    localparam int unsigned CLK_NS = 4;
    localparam int unsigned RESET_PULSE_NS = 40;
    localparam int unsigned RESET_STROBE_SETUP_NS = 40;
    localparam int unsigned RESET_RECOVERY_NS = 40;
    localparam int unsigned STROBE_LOW_NS = 40;
    localparam int unsigned STROBE_HIGH_NS = 20;
    localparam int unsigned REWIND_PULSE_NS = 40;
    localparam int unsigned TIM_W = 8;
    localparam logic [TIM_W-1:0] RESET_CYC =
        TIM_W'((RESET_PULSE_NS + RESET_STROBE_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIM_W-1:0] RECOVER_CYC =
        TIM_W'((RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIM_W-1:0] STROBE_LOW_CYC =
        TIM_W'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIM_W-1:0] STROBE_HIGH_CYC =
        TIM_W'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIM_W-1:0] REWIND_CYC =
        TIM_W'((REWIND_PULSE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        APF_IDLE,
        APF_RST,
        APF_RECOVER,
        APF_STROBE,
        APF_RECOVER_STROBE,
        APF_REWIND
    } apf_state_t;

    // pins toward the buffer
    typedef struct packed {
        logic reset_in_n;
        logic write_n;
        logic read_n;
        logic first_load_or_rewind_n;
        logic chain_in_n;
        logic [DATA_W-1:0] write_word;
    } apf_pins_t;
endpackage

/* File: rtl/apf_host.sv */
// Contract
// RULE_01: reset pulls both pointers to zero
// RULE_02: host resets buffer before any write
// RULE_03: strobes high around reset and recovery
// RULE_04: half-full released high after reset
// RULE_05: write starts on falling strobe if not full
// RULE_06: writes stored sequentially regardless of reads
// RULE_07: half-full falls on next write past half
// RULE_08: half-full rises on read strobe rising edge
// RULE_09: full when write one behind read
// RULE_10: read releases full after delay
// RULE_11: writes ignored while full
// RULE_12: read starts on falling strobe if not empty
// RULE_13: data outputs float while read strobe high
// RULE_14: empty when pointers equal
// RULE_15: write releases empty after delay
// RULE_16: reads ignored while empty
// RULE_17: chain input low selects single device
// RULE_18: rewind moves read pointer to zero
// RULE_19: strobes high during rewind pulse
// RULE_20: half-full re-evaluated after rewind
// RULE_21: first device has first-load low
// RULE_22: chain pulse at last location
// RULE_23: no rewind or half-full when chained
// RULE_24: pointers wrap modulo depth
// RULE_25: chained device acts only with token
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
module apf_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output apf_pkg::apf_pins_t pins,
    input wire logic [apf_pkg::DATA_W-1:0] read_word,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic chain_out_or_half_full_n
);
    // flags arrive asynchronously: two flops before use
    logic [2:0] flag_s1_r, flag_s2_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // idle levels of a freshly reset buffer, so no false full or half follows reset
            flag_s1_r <= 3'h6;
            flag_s2_r <= 3'h6;
        end else begin
            flag_s1_r <= {chain_out_or_half_full_n, full_flag_n, empty_flag_n};
            flag_s2_r <= flag_s1_r;
        end
    end
    logic empty_n_s, full_n_s, half_n_s;
    assign empty_n_s = flag_s2_r[0];
    assign full_n_s = flag_s2_r[1];
    assign half_n_s = flag_s2_r[2];

    apf_pkg::apf_state_t state_r, state_nxt;
    logic [apf_pkg::TIM_W-1:0] tim_r, tim_nxt;
    logic strobe_wr_r, strobe_wr_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic inited_r, inited_nxt;
    logic [apf_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [apf_pkg::CNT_W-1:0] count_r, count_nxt;
    apf_pkg::apf_pins_t pins_r, pins_nxt;
    logic ap_valid_r, ap_valid_nxt, ap_write_r, ap_write_nxt;
    logic [7:0] ap_addr_r, ap_addr_nxt;
    logic hreadyout_r, hreadyout_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;

    logic [apf_pkg::DATA_W-1:0] rd_s1_r, rd_s2_r;
    // bus word is async to hclk; it stands the whole low strobe, so two flops still catch it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_s1_r <= '0;
            rd_s2_r <= '0;
        end else begin
            rd_s1_r <= read_word;
            rd_s2_r <= rd_s1_r;
        end
    end

    logic busy;
    assign busy = (state_r != apf_pkg::APF_IDLE);

    always_comb begin
        state_nxt = state_r;
        tim_nxt = tim_r;
        strobe_wr_nxt = strobe_wr_r;
        ctrl_nxt = ctrl_r;
        inited_nxt = inited_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = rvalid_r;
        count_nxt = count_r;
        pins_nxt = pins_r;
        ap_valid_nxt = 1'b0;
        ap_write_nxt = ap_write_r;
        ap_addr_nxt = ap_addr_r;
        hreadyout_nxt = 1'b1;
        hrdata_nxt = 32'h0000_0000;
        // chain mode and first-in-chain strap follow the control register
        pins_nxt.chain_in_n = ctrl_r[apf_pkg::CTRL_CHAIN_BIT]; // RULE_17
        if (ctrl_r[apf_pkg::CTRL_CHAIN_BIT] && state_r != apf_pkg::APF_REWIND) begin
            pins_nxt.first_load_or_rewind_n = ~ctrl_r[apf_pkg::CTRL_FIRST_BIT]; // RULE_21
        end

        // data phase of a previously taken transfer
        if (ap_valid_r) begin
            if (ap_write_r) begin
                unique case (ap_addr_r)
                    apf_pkg::OFF_CTRL: begin
                        ctrl_nxt[apf_pkg::CTRL_CHAIN_BIT] = hwdata[apf_pkg::CTRL_CHAIN_BIT];
                        ctrl_nxt[apf_pkg::CTRL_FIRST_BIT] = hwdata[apf_pkg::CTRL_FIRST_BIT];
                        if (!busy && hwdata[apf_pkg::CTRL_RESET_BIT]) begin
                            // both strobes driven high in the same cycle that reset falls
                            pins_nxt.write_n = 1'b1; // RULE_03
                            pins_nxt.read_n = 1'b1;
                            pins_nxt.reset_in_n = 1'b0; // RULE_01
                            state_nxt = apf_pkg::APF_RST;
                            tim_nxt = apf_pkg::RESET_CYC;
                            count_nxt = '0;
                            rvalid_nxt = 1'b0;
                        end else if (!busy && hwdata[apf_pkg::CTRL_REWIND_BIT]
                                     && !ctrl_r[apf_pkg::CTRL_CHAIN_BIT]) begin // RULE_23
                            pins_nxt.first_load_or_rewind_n = 1'b0; // RULE_18 RULE_19
                            state_nxt = apf_pkg::APF_REWIND;
                            tim_nxt = apf_pkg::REWIND_CYC;
                        end
                    end
                    apf_pkg::OFF_WDATA: begin
                        // write only once initialised and not full
                        if (!busy && inited_r && full_n_s) begin // RULE_02 RULE_11
                            pins_nxt.write_word = hwdata[apf_pkg::DATA_W-1:0];
                            pins_nxt.write_n = 1'b0; // RULE_05
                            strobe_wr_nxt = 1'b1;
                            state_nxt = apf_pkg::APF_STROBE;
                            tim_nxt = apf_pkg::STROBE_LOW_CYC;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (ap_addr_r)
                    apf_pkg::OFF_CTRL: hrdata_nxt = {28'h0, ctrl_r};
                    apf_pkg::OFF_STATUS: hrdata_nxt = {26'h0, inited_r, rvalid_r,
                        ~half_n_s, ~full_n_s, ~empty_n_s, busy};
                    apf_pkg::OFF_RDATA: begin
                        hrdata_nxt = {23'h0, rdata_r};
                        rvalid_nxt = 1'b0;
                        // reading RDATA launches the next buffer read
                        if (!busy && inited_r && empty_n_s) begin // RULE_16
                            pins_nxt.read_n = 1'b0; // RULE_12
                            strobe_wr_nxt = 1'b0;
                            state_nxt = apf_pkg::APF_STROBE;
                            tim_nxt = apf_pkg::STROBE_LOW_CYC;
                        end
                    end
                    apf_pkg::OFF_COUNT: hrdata_nxt = {18'h0, count_r};
                    default: hrdata_nxt = 32'h0000_0000;
                endcase
            end
        end

        unique case (state_r)
            apf_pkg::APF_IDLE: begin
            end
            apf_pkg::APF_RST: begin
                tim_nxt = tim_r - 1'b1;
                if (tim_r == 8'h01) begin
                    pins_nxt.reset_in_n = 1'b1;
                    state_nxt = apf_pkg::APF_RECOVER;
                    tim_nxt = apf_pkg::RECOVER_CYC; // RULE_03
                end
            end
            apf_pkg::APF_RECOVER, apf_pkg::APF_RECOVER_STROBE: begin
                tim_nxt = tim_r - 1'b1;
                if (tim_r == 8'h01) begin
                    state_nxt = apf_pkg::APF_IDLE;
                    if (state_r == apf_pkg::APF_RECOVER) inited_nxt = 1'b1; // RULE_02
                end
            end
            apf_pkg::APF_STROBE: begin
                tim_nxt = tim_r - 1'b1;
                if (tim_r == 8'h01) begin
                    // rising strobe ends the cycle; data latched before it
                    pins_nxt.write_n = 1'b1;
                    pins_nxt.read_n = 1'b1; // RULE_13
                    if (strobe_wr_r) begin
                        count_nxt = count_r + 1'b1;
                    end else begin
                        rdata_nxt = rd_s2_r;
                        rvalid_nxt = 1'b1;
                        count_nxt = count_r - 1'b1;
                    end
                    state_nxt = apf_pkg::APF_RECOVER_STROBE;
                    tim_nxt = apf_pkg::STROBE_HIGH_CYC;
                end
            end
            apf_pkg::APF_REWIND: begin
                tim_nxt = tim_r - 1'b1;
                if (tim_r == 8'h01) begin
                    pins_nxt.first_load_or_rewind_n = 1'b1;
                    state_nxt = apf_pkg::APF_RECOVER_STROBE;
                    tim_nxt = apf_pkg::STROBE_HIGH_CYC;
                end
            end
            default: state_nxt = apf_pkg::APF_IDLE;
        endcase

        // address phase
        if (hsel && hready && htrans[1]) begin
            ap_valid_nxt = 1'b1;
            ap_write_nxt = hwrite;
            ap_addr_nxt = haddr[7:0];
            // read data is registered, so reads need one wait cycle
            hreadyout_nxt = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= apf_pkg::APF_IDLE;
            tim_r <= '0;
            strobe_wr_r <= 1'b0;
            ctrl_r <= apf_pkg::CTRL_RESET_VAL[3:0];
            inited_r <= 1'b0;
            rdata_r <= '0;
            rvalid_r <= 1'b0;
            count_r <= '0;
            // buffer held in reset with strobes idle until software starts it
            pins_r <= '{reset_in_n: 1'b0, write_n: 1'b1, read_n: 1'b1,
                        first_load_or_rewind_n: 1'b1, chain_in_n: 1'b0, write_word: '0};
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= '0;
            hreadyout_r <= 1'b1;
            hrdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            tim_r <= tim_nxt;
            strobe_wr_r <= strobe_wr_nxt;
            ctrl_r <= ctrl_nxt;
            inited_r <= inited_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            count_r <= count_nxt;
            pins_r <= pins_nxt;
            ap_valid_r <= ap_valid_nxt;
            ap_write_r <= ap_write_nxt;
            ap_addr_r <= ap_addr_nxt;
            hreadyout_r <= hreadyout_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign pins = pins_r;
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
endmodule

/* File: verif/apf_host_sva.sv */
module apf_host_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire apf_pkg::apf_pins_t pins,
    input wire logic empty_flag_n,
    input wire logic full_flag_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_rst_r;
    logic seen_rst_nxt;
    logic rst_low_r;
    logic rst_low_nxt;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // the buffer pin is held low from power-up, so only a completed pulse counts
    always_comb begin
        rst_low_nxt = ~pins.reset_in_n;
        seen_rst_nxt = seen_rst_r | (rst_low_r & pins.reset_in_n);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_rst_r <= 1'b0;
            rst_low_r <= 1'b1;
        end else begin
            seen_rst_r <= seen_rst_nxt;
            rst_low_r <= rst_low_nxt;
        end
    end
    // ten low cycles, then the strobe rises
    sequence s_wr_low;
        (!pins.write_n) [*8] ##1 !pins.write_n ##1 !pins.write_n;
    endsequence
    property p_wr_pulse;
        $fell(pins.write_n) |-> s_wr_low ##1 pins.write_n;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");
    property p_word_hold;
        $fell(pins.write_n) |=> ($stable(pins.write_word)) [*8];
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("write word moved");
    property p_rst_len;
        $fell(pins.reset_in_n) |-> (!pins.reset_in_n) [*8];
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    property p_rst_quiet;
        !pins.reset_in_n |-> pins.write_n && pins.read_n;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("strobe during reset");
    property p_recover;
        $rose(pins.reset_in_n) |-> (pins.write_n && pins.read_n) [*8];
    endproperty
    a_recover: assert property (p_recover) else $error("strobe in recovery");
    property p_first_reset;
        $fell(pins.write_n) |-> seen_rst_r;
    endproperty
    a_first_reset: assert property (p_first_reset) else $error("write before reset");
    property p_wr_gate;
        $fell(pins.write_n) |-> full_flag_n && $past(full_flag_n);
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write while full");
    property p_rd_gate;
        $fell(pins.read_n) |-> empty_flag_n && $past(empty_flag_n);
    endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read while empty");
    property p_rw_quiet;
        !pins.chain_in_n && !pins.first_load_or_rewind_n |-> pins.write_n && pins.read_n;
    endproperty
    a_rw_quiet: assert property (p_rw_quiet) else $error("strobe during rewind");
    property p_one_wait;
        !hreadyout |=> hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("read wait too long");
endmodule

bind apf_host apf_host_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .pins(pins), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));

/* File: verif/apf_fifo_model.sv */
module apf_fifo_model #(parameter int D = 16) (
    input wire apf_pkg::apf_pins_t pins,
    output logic [apf_pkg::DATA_W-1:0] read_word,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic chain_out_or_half_full_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [apf_pkg::DATA_W-1:0] mem [D];
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    int tot = 0;
    bit wgo;
    bit rgo;
    bit wtok;
    bit rtok;
    bit wlast;
    bit rlast;
    initial read_word = '1;
    initial chain_out_or_half_full_n = 1'b1;
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (cnt != D);
    // hands the chain token on with a short low pulse
    task automatic xo_pulse();
        chain_out_or_half_full_n = 1'b0;
        #4;
        chain_out_or_half_full_n = 1'b1;
    endtask
    always @(pins.reset_in_n or pins.first_load_or_rewind_n) begin
        if (!pins.reset_in_n) begin
            wp = 0;
            rp = 0;
            cnt = 0;
            tot = 0;
            wtok = !pins.first_load_or_rewind_n;
            rtok = wtok;
            chain_out_or_half_full_n = 1'b1;
        end else if (!pins.first_load_or_rewind_n && !pins.chain_in_n) begin
            rp = 0;
            cnt = tot;
            chain_out_or_half_full_n = !(cnt > D / 2);
        end
    end
    always @(negedge pins.write_n) begin
        wgo = pins.reset_in_n && cnt < D && (!pins.chain_in_n || wtok);
        if (wgo && cnt >= D / 2 && !pins.chain_in_n) begin
            chain_out_or_half_full_n = 1'b0;
        end
    end
    always @(posedge pins.write_n) begin
        wlast = wgo && pins.chain_in_n && wp == D - 1;
        if (wgo) begin
            mem[wp] = pins.write_word;
            wp = (wp + 1) % D;
            cnt++;
            tot++;
        end
        wgo = 1'b0;
        if (wlast) begin
            wtok = 1'b0;
            xo_pulse();
        end
    end
    always @(negedge pins.read_n) begin
        rgo = pins.reset_in_n && cnt > 0 && (!pins.chain_in_n || rtok);
        if (rgo) read_word = mem[rp];
    end
    // a floating bus is shown as the inverse of its last value
    always @(posedge pins.read_n) begin
        read_word = ~read_word;
        rlast = rgo && pins.chain_in_n && rp == D - 1;
        if (rgo) begin
            rp = (rp + 1) % D;
            cnt--;
            if (cnt <= D / 2 && !pins.chain_in_n) chain_out_or_half_full_n = 1'b1;
        end
        rgo = 1'b0;
        if (rlast) begin
            rtok = 1'b0;
            xo_pulse();
        end
    end
endmodule

/* File: verif/apf_host_tb.sv */
module apf_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 16;
    localparam int HD = D / 2;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, st, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    apf_pkg::apf_pins_t pins;
    logic [apf_pkg::DATA_W-1:0] read_word;
    logic empty_flag_n, full_flag_n, chain_out_or_half_full_n;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'h560f9029;
    int xo_seen = 0;
    bit chain_m = 1'b0;
    logic [31:0] q [$];
    logic [31:0] cp [$];
    apf_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .read_word(read_word), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .chain_out_or_half_full_n(chain_out_or_half_full_n));
    // a shallow model keeps fill and drain short; the host does not depend on depth
    apf_fifo_model #(.D(D)) dev_u (.pins(pins), .read_word(read_word),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .chain_out_or_half_full_n(chain_out_or_half_full_n));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(negedge chain_out_or_half_full_n) if (chain_m) xo_seen++;
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // hready is looked at mid-cycle so its value at the next rising edge is settled
    task automatic wait_rdy(output logic [31:0] d);
        int n;
        @(negedge hclk);
        for (n = 0; n < 100 && hreadyout !== 1'b1; n++) @(negedge hclk);
        if (n == 100) begin
            chk("hready", 32'h1, 32'h0);
            close_out();
        end
        d = hrdata;
        @(posedge hclk);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        logic [31:0] unused;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy(unused);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(r);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic idle(output logic [31:0] s);
        int n;
        for (n = 0; n < 300; n++) begin
            xfer(apf_pkg::OFF_STATUS, 1'b0, 32'h0, s);
            if (s[0] === 1'b0) break;
        end
        if (n == 300) begin
            chk("busy", 32'h0, 32'h1);
            close_out();
        end
    endtask
    function automatic logic [31:0] flags(input int n);
        // no half-full indication while chained
        return {29'h0, n > HD && !chain_m, n >= D, n == 0};
    endfunction
    task automatic push(input int n);
        logic [31:0] v;
        for (int i = 0; i < n; i++) begin
            v = (i == 0) ? 32'h1ff : (i == 1) ? 32'h0 : $random(seed);
            xfer(apf_pkg::OFF_WDATA, 1'b1, v, rv);
            if (i < D) q.push_back({23'h0, v[8:0]});
            idle(st);
            chk("flags", flags(i + 1 > D ? D : i + 1), {29'h0, st[3:1]});
        end
    endtask
    task automatic drain(input int n);
        xfer(apf_pkg::OFF_RDATA, 1'b0, 32'h0, rv);
        idle(st);
        chk("rvalid", 32'h1, {31'h0, st[4]});
        for (int k = 0; k < n; k++) begin
            xfer(apf_pkg::OFF_RDATA, 1'b0, 32'h0, rv);
            chk("word", q.pop_front(), rv & 32'h1ff);
            idle(st);
            chk("flags", flags(n - 2 - k < 0 ? 0 : n - 2 - k), {29'h0, st[3:1]});
        end
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(apf_pkg::OFF_CTRL, 1'b1, 32'h1, rv);
        idle(st);
        chk("status", 32'h22, st & 32'h2f);
        push(D + 1);
        xfer(apf_pkg::OFF_COUNT, 1'b0, 32'h0, rv);
        chk("count", D, rv);
        drain(D);
        push(3);
        xfer(apf_pkg::OFF_CTRL, 1'b1, 32'h1, rv);
        idle(st);
        chk("flags", flags(0), {29'h0, st[3:1]});
        q.delete();
        push(10);
        cp = q;
        drain(10);
        xfer(apf_pkg::OFF_CTRL, 1'b1, 32'h2, rv);
        idle(st);
        chk("flags", flags(10), {29'h0, st[3:1]});
        q = cp;
        drain(10);
        chain_m = 1'b1;
        xfer(apf_pkg::OFF_CTRL, 1'b1, 32'hd, rv);
        idle(st);
        xfer(apf_pkg::OFF_CTRL, 1'b0, 32'h0, rv);
        chk("ctrl", 32'hc, rv);
        push(D);
        xfer(apf_pkg::OFF_CTRL, 1'b1, 32'he, rv);
        idle(st);
        chk("flags", flags(D), {29'h0, st[3:1]});
        drain(D);
        xfer(apf_pkg::OFF_WDATA, 1'b1, 32'h5a, rv);
        idle(st);
        chk("flags", flags(0), {29'h0, st[3:1]});
        chk("chain pulses", 32'h2, xo_seen);
        close_out();
    end
endmodule
